// ===== design/skt_top.sv
// Key presence and teach-in controller of a key-operated safety bus slave.
// Assumes all inputs are synchronous to ref_clk; rst models power-up.
module skt_top
    import skt_pkg::*;
#(
    parameter int HALF_SEC_CYC_P = skt_pkg::HALF_SEC_CYC
) (
    // Clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      rst,
    // Key reader
    input  wire logic                      key_present,
    input  wire logic [skt_pkg::KEY_W-1:0] key_code,
    input  wire logic                      key_read_err,
    // Bus status and address programming
    input  wire logic                      bus_connected,
    input  wire logic                      bus_running,
    input  wire logic                      addr_wr,
    input  wire logic [skt_pkg::ADDR_W-1:0] addr_wr_data,
    input  wire logic                      factory_init,
    // Internal diagnostics
    input  wire logic                      int_fault,
    // Safety sequence select and status
    output logic                           seq_nonzero,
    output logic                           teach_active,
    output logic [skt_pkg::ADDR_W-1:0]     slave_addr,
    output logic                           addr_valid,
    // Indicators
    output logic                           led_green,
    output logic                           led_yellow,
    output logic                           led_red
);
    import skt_pkg::*;

    skt_store_if sif ();

    skt_state_e        st;
    skt_state_e        next_st;
    logic [DIV_W-1:0]  div_cnt;
    logic              half_tick;
    logic              div_wrap;
    logic [PH_W-1:0]   ph_cnt;
    logic              blink;
    logic              removed_seen;
    logic              next_seq;
    logic              next_green;
    logic              next_yellow;
    logic              next_removed;

    // Store holds code and address across power cycles
    skt_code_store u_store (
        .ref_clk (ref_clk),
        .rst     (rst),
        .st      (sif.store)
    );

    // Key classification against the stored codes
    wire key_ok       = key_present && sif.active_ok && (key_code == sif.active_code);
    wire key_disabled = sif.disabled_ok && (key_code == sif.disabled_code);
    wire key_new      = key_present && !key_ok && !key_disabled;
    wire fault_now    = int_fault || (key_present && key_read_err);
    wire addr_ok      = (sif.slave_addr >= ADDR_MIN) && (sif.slave_addr <= ADDR_MAX);
    wire st_change    = (next_st != st);
    wire selftest_end = (div_cnt == DIV_W'(SELFTEST_CYC - 1));
    wire teach_full   = half_tick && (ph_cnt == TEACH_HALF - 9'h001);
    wire stby_end     = half_tick && (ph_cnt == STBY_HALF - 9'h001);

    // Store requests
    assign sif.factory_init = factory_init;
    assign sif.new_code     = key_code;
    assign sif.addr_wr      = addr_wr;
    assign sif.addr_data    = addr_wr_data;
    assign sif.commit = (st == ST_TEACH) && key_present && !key_ok
                        && !key_disabled && !fault_now && teach_full;

    // Half-second divider; one divider keeps all slow rates phase aligned.
    // During self-test it runs on to the self-test length instead, so a short
    // blink period can never cut the self-test short.
    assign half_tick = (st != ST_SELFTEST) && (div_cnt == DIV_W'(HALF_SEC_CYC_P - 1));
    assign div_wrap  = (st == ST_SELFTEST) ? selftest_end : half_tick;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            div_cnt <= '0;
        end else if (div_wrap) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 25'h0000001;
        end
    end

    // Half-second phase count, restarted on every state change
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ph_cnt <= '0;
        end else if (st_change) begin
            ph_cnt <= '0;
        end else if (half_tick) begin
            ph_cnt <= ph_cnt + 9'h001;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            blink <= 1'b0;
        end else if (half_tick) begin
            blink <= !blink;
        end
    end

    // State transitions; fault takes priority over every other event
    always_comb begin
        next_st = st;
        unique case (st)
            ST_SELFTEST: begin
                if (fault_now) begin
                    next_st = ST_FAULT;
                end else if (selftest_end) begin
                    // new key at connect starts teach
                    if (bus_connected && key_new) begin
                        next_st = ST_TEACH;
                    end else begin
                        next_st = ST_STBY;
                    end
                end
            end
            ST_STBY: begin
                if (fault_now) begin
                    next_st = ST_FAULT;
                end else if (key_ok) begin
                    next_st = ST_NORM;
                end else if (bus_connected && key_new) begin
                    next_st = ST_TEACH;
                end else if (stby_end) begin
                    next_st = ST_NORM;
                end
            end
            ST_TEACH: begin
                if (fault_now) begin
                    next_st = ST_FAULT;
                end else if (!key_present || key_disabled || key_ok) begin
                    next_st = ST_NORM;
                end else if (sif.commit) begin
                    next_st = ST_DONE;
                end
            end
            ST_DONE: begin
                if (fault_now) begin
                    next_st = ST_FAULT;
                end
            end
            ST_NORM: begin
                if (fault_now) begin
                    next_st = ST_FAULT;
                end
            end
            ST_FAULT: begin
                if (!fault_now && removed_seen && key_present) begin
                    next_st = ST_NORM;
                end
            end
            default: begin
                next_st = ST_FAULT;
            end
        endcase
    end

    // Remember a key removal while the fault is latched
    assign next_removed = (st == ST_FAULT) && (removed_seen || !key_present);

    // key sequence only for permissible key
    // zero outside normal, so in teach
    assign next_seq = (next_st == ST_NORM) && key_ok && addr_ok && !fault_now;

    // Green: steady with valid key, blinking in standby and teach, else off
    assign next_green = ((next_st == ST_NORM) && next_seq)
                        || (((next_st == ST_STBY) || (next_st == ST_TEACH)) && blink);
    assign next_yellow = (next_st == ST_NORM) && !key_present && bus_running;

    // State register; leaving reset always starts with the self-test
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st           <= ST_SELFTEST;
            removed_seen <= 1'b0;
        end else begin
            st           <= next_st;
            removed_seen <= next_removed;
        end
    end

    // Registered outputs, all safe-low after reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            seq_nonzero  <= 1'b0;
            teach_active <= 1'b0;
            led_green    <= 1'b0;
            led_yellow   <= 1'b0;
            led_red      <= 1'b0;
            addr_valid   <= 1'b0;
        end else begin
            seq_nonzero  <= next_seq;
            teach_active <= (next_st == ST_TEACH);
            led_green    <= next_green;
            led_yellow   <= next_yellow;
            led_red      <= (next_st == ST_FAULT);
            addr_valid   <= addr_ok;
        end
    end

    // Address output mirrors the stored register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            slave_addr <= ADDR_DELIVERY;
        end else begin
            slave_addr <= sif.slave_addr;
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_zero_on_removal: assert property (
        !key_present |=> !seq_nonzero)
        else $error("key sequence sent without key");

    chk_valid_key_seq: assert property (
        (st == ST_NORM && key_ok && addr_ok && !fault_now) |=> seq_nonzero)
        else $error("valid key did not raise key sequence");

    chk_fault_red: assert property (
        int_fault |=> (!seq_nonzero && led_red && st == ST_FAULT))
        else $error("fault did not force zero sequence and red");

    chk_teach_zero: assert property (
        (st == ST_TEACH || teach_active) |-> !seq_nonzero)
        else $error("key sequence during teach-in");

    chk_latest_code: assert property (
        seq_nonzero |-> $past(key_code == sif.active_code && sif.active_ok))
        else $error("non-latest code accepted");

    chk_standby_exit: assert property (
        (st == ST_STBY && key_ok && !fault_now) |=> (st == ST_NORM))
        else $error("standby not left on latest key");

    chk_teach_abandon: assert property (
        (st == ST_TEACH && !key_present && !int_fault) |-> (!sif.commit ##1 st == ST_NORM))
        else $error("teach-in not abandoned on key loss");

    chk_commit_green_off: assert property (
        sif.commit |=> (st == ST_DONE && !led_green && !seq_nonzero))
        else $error("teach completion not followed by done state");

    chk_addr_range: assert property (
        addr_valid |-> ($past(sif.slave_addr) != ADDR_DELIVERY))
        else $error("address 0 flagged valid");

    chk_default_safe: assert property (
        seq_nonzero |-> (st == ST_NORM))
        else $error("key sequence outside normal operation");

    chk_green_steady: assert property (
        (st == ST_NORM && seq_nonzero) |-> led_green)
        else $error("green not steady with valid key");

    chk_yellow_ready: assert property (
        (next_st == ST_NORM && !key_present && bus_running) |=> (led_yellow && !led_green))
        else $error("yellow not lit after removal");

    chk_selftest_quiet: assert property (
        (st == ST_SELFTEST) |-> (!seq_nonzero && !led_green))
        else $error("output active during self-test");

    chk_standby_zero: assert property (
        (st == ST_STBY) |-> !seq_nonzero)
        else $error("key sequence in standby");

    chk_standby_window: assert property (
        (st == ST_STBY) |-> (ph_cnt < STBY_HALF))
        else $error("standby outlasted its window");

    chk_teach_start: assert property (
        (st == ST_STBY && !fault_now && bus_connected && key_new) |=> teach_active)
        else $error("new key did not start teach-in");

    chk_teach_blink: assert property (
        (st == ST_TEACH) |-> (led_green == $past(blink)))
        else $error("green not following blink in teach-in");

    chk_disabled_refused: assert property (
        (st == ST_STBY && key_disabled) |=> !teach_active)
        else $error("disabled code started teach-in");

    chk_foreign_zero: assert property (
        (key_present && !key_ok) |=> !seq_nonzero)
        else $error("key sequence for untaught code");

    chk_done_quiet: assert property (
        (st == ST_DONE) |-> (!seq_nonzero && !led_green && !teach_active))
        else $error("output active after teach-in completion");

    chk_fault_quiet: assert property (
        (st == ST_FAULT) |-> (!seq_nonzero && led_red))
        else $error("fault state without red and zero sequence");

    chk_fault_clear: assert property (
        (st == ST_FAULT && removed_seen && key_present && !fault_now)
            |=> (st == ST_NORM && !led_red))
        else $error("latched fault not cleared by key cycle");

endmodule : skt_top

// ===== design/skt_pkg.sv
// Package for the key presence and teach-in controller: widths, timing, states.
// Assumes a single 40 MHz clock; every slow rate comes from one divider.
package skt_pkg;

    // Data widths
    localparam int KEY_W  = 32;            // Electronic key code width
    localparam int ADDR_W = 5;             // Slave address width
    localparam int DIV_W  = 25;            // Half-second divider width
    localparam int PH_W   = 9;             // Half-second phase counter width

    // Clock and derived timing
    localparam int CLK_HZ        = 40_000_000;
    localparam int HALF_S_MS     = 500;    // Blink half period, ms
    localparam int HALF_SEC_CYC  = CLK_HZ / 1000 * HALF_S_MS;
    localparam int TEACH_S       = 60;     // Teach-in hold time, s
    localparam int POWERUP_MIN   = 3;      // Power-up flash and standby time, min
    localparam int SELFTEST_US   = 50;     // Self-test duration, us
    localparam int SELFTEST_CYC  = CLK_HZ / 1_000_000 * SELFTEST_US;
    localparam logic [PH_W-1:0] TEACH_HALF = PH_W'(TEACH_S * 1000 / HALF_S_MS);
    localparam logic [PH_W-1:0] STBY_HALF  = PH_W'(POWERUP_MIN * 60 * 1000 / HALF_S_MS);

    // Slave address range and delivery value
    localparam logic [ADDR_W-1:0] ADDR_MIN      = 5'h01;
    localparam logic [ADDR_W-1:0] ADDR_MAX      = 5'h1f;
    localparam logic [ADDR_W-1:0] ADDR_DELIVERY = 5'h00;

    // Controller states
    typedef enum logic [2:0] {
        ST_SELFTEST = 3'b000,
        ST_STBY     = 3'b001,
        ST_TEACH    = 3'b010,
        ST_DONE     = 3'b011,
        ST_NORM     = 3'b100,
        ST_FAULT    = 3'b101
    } skt_state_e;

endpackage : skt_pkg

// ===== design/skt_store_if.sv
// Interface between the controller and the non-volatile code and address store.
// Assumes both ends run on the same clock.
interface skt_store_if;
    import skt_pkg::*;

    logic              factory_init;       // Return to delivery state
    logic              commit;             // Store taught code, disable old one
    logic [KEY_W-1:0]  new_code;
    logic              addr_wr;
    logic [ADDR_W-1:0] addr_data;
    logic [KEY_W-1:0]  active_code;
    logic              active_ok;
    logic [KEY_W-1:0]  disabled_code;
    logic              disabled_ok;
    logic [ADDR_W-1:0] slave_addr;

    modport ctrl  (output factory_init, commit, new_code, addr_wr, addr_data,
                   input  active_code, active_ok, disabled_code, disabled_ok, slave_addr);
    modport store (input  factory_init, commit, new_code, addr_wr, addr_data,
                   output active_code, active_ok, disabled_code, disabled_ok, slave_addr);
endinterface : skt_store_if

// ===== design/skt_code_store.sv
// Non-volatile store for the taught key code, the disabled code and the slave address.
// Assumes the content survives reset; only factory_init returns it to delivery state.
module skt_code_store
    import skt_pkg::*;
(
    // Clock and reset (reset only gates the checks)
    input wire logic   ref_clk,
    input wire logic   rst,
    // Controller side
    skt_store_if.store st
);

    // Models retained memory, so no reset: a power cycle must not forget the key
    always_ff @(posedge ref_clk) begin
        if (st.factory_init) begin
            st.active_ok   <= 1'b0;
            st.disabled_ok <= 1'b0;
            st.active_code   <= '0;
            st.disabled_code <= '0;
        end else if (st.commit) begin
            st.disabled_code <= st.active_code;
            st.disabled_ok   <= st.active_ok;
            st.active_code   <= st.new_code;
            st.active_ok     <= 1'b1;
        end
    end

    // Address written by tool or master
    always_ff @(posedge ref_clk) begin
        if (st.factory_init) begin
            st.slave_addr <= ADDR_DELIVERY;
        end else if (st.addr_wr) begin
            st.slave_addr <= st.addr_data;
        end
    end

    chk_commit_disables_old: assert property (
        @(posedge ref_clk) disable iff (rst)
        (st.commit && !st.factory_init) |=>
            (st.disabled_code == $past(st.active_code) && st.active_code == $past(st.new_code)))
        else $error("old code not disabled on commit");

    chk_addr_stored: assert property (
        @(posedge ref_clk) disable iff (rst)
        (st.addr_wr && !st.factory_init) |=> st.slave_addr == $past(st.addr_data))
        else $error("written slave address not stored");

endmodule : skt_code_store

// ===== bench/skt_bus_model.sv
// Bus master model: connection state, traffic, address writes.
// Assumes the bench commands it with levels and one-cycle pulses on ref_clk.
module skt_bus_model
    import skt_pkg::*;
(
    // Clock and bench commands
    input  wire logic                       ref_clk,
    input  wire logic                       link_on,
    input  wire logic                       wr_req,
    input  wire logic [skt_pkg::ADDR_W-1:0] wr_val,
    // Bus side towards the slave
    output logic                            bus_connected,
    output logic                            bus_running,
    output logic                            addr_wr = 1'b0,
    output logic [skt_pkg::ADDR_W-1:0]      addr_wr_data = 5'h00
);
    timeunit 1ns;
    timeprecision 1ps;

    // Connection and master traffic follow the link; a disconnect drops both
    // disconnect before activation
    assign bus_connected = link_on;
    assign bus_running   = link_on;

    // Address write launched just after the edge; idle data is inverted each cycle
    // so a stale value can never pass for a fresh write
    // master writes address
    always @(posedge ref_clk) begin
        addr_wr      <= wr_req;
        addr_wr_data <= wr_req ? wr_val : ~addr_wr_data;
    end
endmodule : skt_bus_model

// ===== bench/skt_top_tb_top.sv
// Self-checking bench for the key presence and teach-in controller.
// Assumes the 0.5 s divider is shortened to a few cycles to keep the run short.
module skt_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import skt_pkg::*;

    localparam int HALF      = 20;
    localparam int TEACH_CYC = 120 * HALF;
    localparam logic [KEY_W-1:0] KEY_A = 32'h1234_5678;
    localparam logic [KEY_W-1:0] KEY_B = 32'h0bad_c0de;

    logic              ref_clk = 1'b0;
    logic              rst;
    logic              key_present;
    logic [KEY_W-1:0]  key_code;
    logic              key_read_err;
    logic              factory_init;
    logic              int_fault;
    logic              link_on;
    logic              wr_req;
    logic [ADDR_W-1:0] wr_val;
    logic              bus_connected;
    logic              bus_running;
    logic              addr_wr;
    logic [ADDR_W-1:0] addr_wr_data;
    logic              seq_nonzero;
    logic              teach_active;
    logic [ADDR_W-1:0] slave_addr;
    logic              addr_valid;
    logic              led_green;
    logic              led_yellow;
    logic              led_red;
    int                n_errors = 0;
    int                checks = 0;

    // 40 MHz clock
    always #12.5 ref_clk = ~ref_clk;

    // Design and bus partner
    skt_top #(.HALF_SEC_CYC_P(HALF)) skt_top_i (
        .ref_clk(ref_clk), .rst(rst), .key_present(key_present), .key_code(key_code),
        .key_read_err(key_read_err), .bus_connected(bus_connected),
        .bus_running(bus_running), .addr_wr(addr_wr), .addr_wr_data(addr_wr_data),
        .factory_init(factory_init), .int_fault(int_fault), .seq_nonzero(seq_nonzero),
        .teach_active(teach_active), .slave_addr(slave_addr), .addr_valid(addr_valid),
        .led_green(led_green), .led_yellow(led_yellow), .led_red(led_red));
    skt_bus_model skt_bus_model_i (
        .ref_clk(ref_clk), .link_on(link_on), .wr_req(wr_req), .wr_val(wr_val),
        .bus_connected(bus_connected), .bus_running(bus_running),
        .addr_wr(addr_wr), .addr_wr_data(addr_wr_data));

    // Compare tasks, one per kind of result
    task automatic chk_bit(input logic got, input logic exp, input string what);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %0t %s: got %b expected %b", $time, what, got, exp);
        end
    endtask : chk_bit

    task automatic chk_addr(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] exp,
                            input string what);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : chk_addr

    task automatic stop_test;
        $display("Summary: %0d checks, %0d mismatches", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    // Disconnect and power up again; outputs must stay quiet through self-test
    task automatic power_cycle;
        link_on = 1'b0;
        key_present = 1'b0;
        rst = 1'b1;
        repeat (8) @(negedge ref_clk);
        rst = 1'b0;
        link_on = 1'b1;
        repeat (1990) @(negedge ref_clk);
        chk_bit(seq_nonzero, 1'b0, "self-test sequence");
        chk_bit(led_green, 1'b0, "self-test green");
        repeat (20) @(negedge ref_clk);
    endtask : power_cycle

    // Delivery address, then writes at both ends of the range and outside it
    task automatic t_addr;
        logic [ADDR_W-1:0] vals [4] = '{5'h00, 5'h1f, 5'h01, 5'h05};
        chk_addr(slave_addr, 5'h00, "delivery address");
        chk_bit(addr_valid, 1'b0, "address 0 invalid");
        foreach (vals[i]) begin
            wr_req = 1'b1;
            wr_val = vals[i];
            @(negedge ref_clk);
            wr_req = 1'b0;
            repeat (4) @(negedge ref_clk);
            chk_addr(slave_addr, vals[i], "stored address");
            chk_bit(addr_valid, vals[i] != 5'h00, "address validity");
        end
        $display("test address done");
    endtask : t_addr

    // Standby after power-up: green flashes, no key sequence
    task automatic t_standby;
        int   flips = 0;
        logic g = led_green;
        logic bad = 1'b0;
        repeat (3 * HALF) begin
            @(negedge ref_clk);
            bad |= (seq_nonzero !== 1'b0);
            flips += (led_green !== g);
            g = led_green;
        end
        chk_bit(bad, 1'b0, "standby sequence");
        chk_bit(flips >= 2, 1'b1, "standby flashing");
        $display("test standby done");
    endtask : t_standby

    // Teach a key; hold of 0 means keep it in to the end, else pull it after hold cycles
    task automatic t_teach(input logic [KEY_W-1:0] code, input int hold);
        int   n = 0;
        int   flips = 0;
        logic g;
        logic bad = 1'b0;
        key_code = code;
        key_present = 1'b1;
        while (teach_active !== 1'b1 && n < 10) begin
            @(negedge ref_clk);
            n++;
        end
        chk_bit(teach_active, 1'b1, "teach start");
        g = led_green;
        n = 0;
        while (teach_active === 1'b1 && n < TEACH_CYC + 4 * HALF) begin
            @(negedge ref_clk);
            n++;
            bad |= (seq_nonzero !== 1'b0);
            flips += (led_green !== g);
            g = led_green;
            if (n == hold) key_present = 1'b0;
        end
        chk_bit(bad, 1'b0, "zero sequence in teach");
        chk_bit(teach_active, 1'b0, "teach end");
        if (teach_active !== 1'b0) stop_test();
        if (hold == 0) begin
            chk_bit(n >= TEACH_CYC - HALF && n <= TEACH_CYC + HALF, 1'b1, "teach time");
            chk_bit(flips >= 118 && flips <= 121, 1'b1, "teach flashing");
            chk_bit(led_green, 1'b0, "green off after teach");
        end else begin
            chk_bit(n <= hold + 3, 1'b1, "teach abandoned");
        end
        key_present = 1'b0;
        $display("test teach done");
    endtask : t_teach

    // Insert a key after power-up and pull it again
    task automatic t_use(input logic [KEY_W-1:0] code, input logic ok);
        key_code = code;
        key_present = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk_bit(seq_nonzero, ok, "key sequence");
        chk_bit(teach_active, 1'b0, "no teach start");
        chk_bit(led_red, 1'b0, "red off after power-up");
        if (ok) chk_bit(led_green, 1'b1, "green steady");
        key_present = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk_bit(seq_nonzero, 1'b0, "key withdrawn");
        if (ok) chk_bit(led_yellow, 1'b1, "ready indicator");
        $display("test key use done");
    endtask : t_use

    // Internal fault, latch until key cycle, then an unreadable key
    task automatic t_fault(input logic [KEY_W-1:0] code);
        key_code = code;
        key_present = 1'b1;
        repeat (3) @(negedge ref_clk);
        int_fault = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk_bit(seq_nonzero, 1'b0, "fault sequence");
        chk_bit(led_red, 1'b1, "fault red");
        int_fault = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk_bit(led_red, 1'b1, "fault latched");
        key_present = 1'b0;
        repeat (2) @(negedge ref_clk);
        key_present = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk_bit(seq_nonzero, 1'b1, "fault cleared");
        key_read_err = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk_bit(led_red, 1'b1, "defective key");
        key_read_err = 1'b0;
        key_present = 1'b0;
        $display("test fault done");
    endtask : t_fault

    // Main sequence
    initial begin
        rst = 1'b1;
        key_present = 1'b0;
        key_code = 32'h0000_0000;
        key_read_err = 1'b0;
        factory_init = 1'b0;
        int_fault = 1'b0;
        link_on = 1'b0;
        wr_req = 1'b0;
        wr_val = 5'h00;
        repeat (8) @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
        factory_init = 1'b1;
        @(negedge ref_clk);
        factory_init = 1'b0;
        power_cycle();
        t_addr();
        t_standby();
        t_teach(KEY_A, 0);
        power_cycle();
        t_use(KEY_A, 1'b1);
        power_cycle();
        t_teach(KEY_B, 10 * HALF);
        power_cycle();
        t_use(KEY_A, 1'b1);
        power_cycle();
        t_teach(KEY_B, 0);
        power_cycle();
        t_use(KEY_B, 1'b1);
        t_fault(KEY_B);
        power_cycle();
        t_use(KEY_A, 1'b0);
        stop_test();
    end
endmodule : skt_top_tb_top
